// >>> src/fan_speed_pwm_control.sv
// Fan speed PWM generator with temperature ramp, command mode and fan alarm logic.
// Contract
// - Host selects temperature or command speed control.
// - Temperature mode: one duty proportional to temperature.
// - Register 0xf9 holds full-speed temperature.
// - Speed command write switches to command mode.
// - Command mode duty follows latest command.
// - Host selects 5 or 10 degree slope.
// - Temperature mode, below enabled off temperature: duty is zero.
// - Above alarm temperature in temperature mode: alarm and full speed.
// - Configuration selects remote or board sensor.
// - Unconfigured: temperature mode, remote sensor.
// - Defaults: setpoint 40, slope 5 degrees.
// - Default idle duty 55 percent below ramp.
// - Nine fans monitored, fail below 2000 ppm.
// - Alarm outputs on fan fail or sensor open.
// - PWM output defaults to 2.5 kHz.
// - Fan count configurable from one to nine.
// - Per-fan pass/fail readable by host.
// - Sensor status and temperatures readable by host.
// - Disabled fan never raises an alarm.
// - Simultaneous writes: primary port wins.
// - Any alarm forces full speed on every enabled fan.
`timescale 1ns/1ns
`include "fan_consts.svh"

module fan_speed_pwm_control #(
	parameter int unsigned TACH_WINDOW_CYC = `FAN_TACH_WINDOW_CYC
) (
	// Clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	// Primary register port
	input  wire fan_pkg::reg_wr_s           i_pri_wr,
	input  wire fan_pkg::reg_rd_s           i_pri_rd,
	output logic [7:0]                      o_pri_rd_data,
	// Secondary register port
	input  wire fan_pkg::reg_wr_s           i_sec_wr,
	input  wire fan_pkg::reg_rd_s           i_sec_rd,
	output logic [7:0]                      o_sec_rd_data,
	// Sensors
	input  wire logic [7:0]                 i_remote_temp,
	input  wire logic [7:0]                 i_board_temp,
	input  wire logic                       i_sensor_open,
	// Fans
	input  wire logic [`FAN_NUM_FANS-1:0]   i_tach,
	output logic [`FAN_NUM_FANS-1:0]        o_fan_pwm,
	// Alarm indicators and relays
	output logic                            o_led_alarm,
	output logic                            o_led_normal,
	output logic                            o_relay_nc_closed,
	output logic                            o_relay_no_closed
);

	typedef struct packed {
		fan_pkg::ctrl_mode_e          mode;
		logic                         board_sensor;
		logic                         slope_wide;
		logic                         off_en;
		logic [7:0]                   setpoint;
		logic [7:0]                   off_temp;
		logic [7:0]                   alarm_temp;
		logic [6:0]                   idle_duty;
		logic [6:0]                   cmd_duty;
		logic [`FAN_NUM_FANS-1:0]     fan_en;
		logic [6:0]                   prescale;
		logic [6:0]                   step;
		logic [6:0]                   duty_active;
		logic [23:0]                  window_cnt;
		logic                         window_end;
		logic [`FAN_NUM_FANS-1:0]     fan_pwm;
		logic                         alarm;
		logic [7:0]                   pri_rd_data;
		logic [7:0]                   sec_rd_data;
	} ctrl_state_s;

	localparam logic [6:0]  PrescaleLast = 7'(`FAN_PWM_PRESCALE - 1);
	localparam logic [6:0]  StepLast     = 7'(`FAN_PWM_STEPS - 1);
	localparam logic [23:0] WindowLast   = 24'(TACH_WINDOW_CYC - 1);

	ctrl_state_s              s_q;
	ctrl_state_s              s_d;
	logic [`FAN_NUM_FANS-1:0] fan_fail;
	logic [`FAN_NUM_FANS-1:0] fan_fail_seen;
	logic [7:0]               temp;
	logic                     temp_alarm;
	logic                     any_alarm;
	logic [6:0]               duty_target;

	genvar g;
	generate
		for (g = 0; g < `FAN_NUM_FANS; g++) begin : g_tach
			fan_tach_monitor u_tach (
				.i_clk        (i_clk),
				.i_rst        (i_rst),
				.i_tach       (i_tach[g]),
				.i_window_end (s_q.window_end),
				.o_fail       (fan_fail[g])
			);
		end
	endgenerate

	// Readback is registered so that both ports see a stable byte one cycle after the request.
	function automatic logic [7:0] read_reg(input logic [7:0] addr);
		logic [7:0] val;
		val = 8'h00;
		unique case (addr)
			`FAN_REG_CONFIG: begin
				val[`FAN_CFG_MODE_BIT]   = (s_q.mode == fan_pkg::MODE_CMD);
				val[`FAN_CFG_SENSOR_BIT] = s_q.board_sensor;
				val[`FAN_CFG_SLOPE_BIT]  = s_q.slope_wide;
				val[`FAN_CFG_OFF_EN_BIT] = s_q.off_en;
			end
			`FAN_REG_SPEED_CMD:   val = {1'b0, s_q.cmd_duty};
			`FAN_REG_OFF_TEMP:    val = s_q.off_temp;
			`FAN_REG_ALARM_TEMP:  val = s_q.alarm_temp;
			`FAN_REG_IDLE_DUTY:   val = {1'b0, s_q.idle_duty};
			`FAN_REG_FAN_EN_LO:   val = s_q.fan_en[7:0];
			`FAN_REG_FAN_EN_HI:   val = {7'h00, s_q.fan_en[8]};
			`FAN_REG_FAIL_LO:     val = fan_fail_seen[7:0];
			`FAN_REG_STATUS:      val = {4'h0, temp_alarm, s_q.alarm, i_sensor_open,
				fan_fail_seen[8]};
			`FAN_REG_SETPOINT:    val = s_q.setpoint;
			`FAN_REG_REMOTE_TEMP: val = i_remote_temp;
			`FAN_REG_BOARD_TEMP:  val = i_board_temp;
			default:              val = 8'h00;
		endcase
		return val;
	endfunction

	always_comb begin
		logic [9:0]          ramp_base;
		logic [9:0]          above;
		logic [13:0]         rise;
		logic [6:0]          span;
		logic [7:0]          slope;
		fan_pkg::reg_wr_s    wr;
		ramp_base   = 10'h000;
		above       = 10'h000;
		rise        = 14'h0000;
		span        = 7'h00;
		slope       = 8'h00;
		wr          = '0;
		duty_target = 7'h00;

		fan_fail_seen = fan_fail & s_q.fan_en;
		temp = s_q.board_sensor ? i_board_temp : i_remote_temp;
		temp_alarm = (s_q.mode == fan_pkg::MODE_TEMP) && (temp > s_q.alarm_temp);
		any_alarm = temp_alarm || (|fan_fail_seen) || i_sensor_open;

		slope = s_q.slope_wide ? `FAN_SLOPE_WIDE : `FAN_SLOPE_NARROW;
		ramp_base = {2'b00, s_q.setpoint} - {2'b00, slope};
		above = {2'b00, temp} - ramp_base;
		span = `FAN_DUTY_FULL - s_q.idle_duty;
		if (any_alarm) begin
			duty_target = `FAN_DUTY_FULL;
		end else if (s_q.mode == fan_pkg::MODE_CMD) begin
			duty_target = s_q.cmd_duty;
		end else if (s_q.off_en && temp < s_q.off_temp) begin
			duty_target = 7'h00;
		end else if (temp >= s_q.setpoint) begin
			duty_target = `FAN_DUTY_FULL;
		end else if (ramp_base[9] || {2'b00, temp} < ramp_base) begin
			duty_target = s_q.idle_duty;
		end else begin
			rise = 14'(span * above[6:0]);
			rise = s_q.slope_wide ? 14'(rise / 14'd10) : 14'(rise / 14'd5);
			duty_target = s_q.idle_duty + rise[6:0];
		end

		s_d = s_q;
		s_d.alarm = any_alarm;

		// A secondary write in the same cycle as a primary one is dropped.
		wr = i_pri_wr.en ? i_pri_wr : i_sec_wr;
		if (wr.en) begin
			unique case (wr.addr)
				`FAN_REG_CONFIG: begin
					s_d.mode = wr.data[`FAN_CFG_MODE_BIT] ? fan_pkg::MODE_CMD
						: fan_pkg::MODE_TEMP;
					s_d.board_sensor = wr.data[`FAN_CFG_SENSOR_BIT];
					s_d.slope_wide   = wr.data[`FAN_CFG_SLOPE_BIT];
					s_d.off_en       = wr.data[`FAN_CFG_OFF_EN_BIT];
				end
				`FAN_REG_SPEED_CMD: begin
					s_d.cmd_duty = (wr.data > 8'(`FAN_DUTY_FULL)) ? `FAN_DUTY_FULL
						: wr.data[6:0];
					s_d.mode = fan_pkg::MODE_CMD;
				end
				`FAN_REG_OFF_TEMP:   s_d.off_temp = wr.data;
				`FAN_REG_ALARM_TEMP: s_d.alarm_temp = wr.data;
				`FAN_REG_IDLE_DUTY: begin
					s_d.idle_duty = (wr.data > 8'(`FAN_DUTY_FULL)) ? `FAN_DUTY_FULL
						: wr.data[6:0];
				end
				`FAN_REG_FAN_EN_LO:  s_d.fan_en[7:0] = wr.data;
				`FAN_REG_FAN_EN_HI:  s_d.fan_en[8] = wr.data[0];
				`FAN_REG_SETPOINT:   s_d.setpoint = wr.data;
				default: begin
				end
			endcase
		end

		s_d.pri_rd_data = i_pri_rd.en ? read_reg(i_pri_rd.addr) : s_q.pri_rd_data;
		s_d.sec_rd_data = i_sec_rd.en ? read_reg(i_sec_rd.addr) : s_q.sec_rd_data;

		// The duty is taken at the start of a period, except that an alarm applies full duty at once.
		s_d.prescale = (s_q.prescale == PrescaleLast) ? 7'h00 : s_q.prescale + 7'h01;
		if (s_q.prescale == PrescaleLast) begin
			s_d.step = (s_q.step == StepLast) ? 7'h00 : s_q.step + 7'h01;
			if (s_q.step == StepLast) begin
				s_d.duty_active = duty_target;
			end
		end
		if (any_alarm) begin
			s_d.duty_active = `FAN_DUTY_FULL;
		end
		s_d.fan_pwm = {`FAN_NUM_FANS{s_q.step < s_q.duty_active}} & s_q.fan_en;

		s_d.window_end = (s_q.window_cnt == WindowLast);
		s_d.window_cnt = s_d.window_end ? 24'h000000 : s_q.window_cnt + 24'h000001;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_q             <= '0;
			s_q.mode        <= fan_pkg::MODE_TEMP;
			s_q.setpoint    <= `FAN_RST_SETPOINT;
			s_q.off_temp    <= `FAN_RST_OFF_TEMP;
			s_q.alarm_temp  <= `FAN_RST_ALARM_TEMP;
			s_q.idle_duty   <= `FAN_RST_IDLE_DUTY;
			s_q.fan_en      <= `FAN_RST_FAN_EN;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_pri_rd_data     = s_q.pri_rd_data;
	assign o_sec_rd_data     = s_q.sec_rd_data;
	assign o_fan_pwm         = s_q.fan_pwm;
	assign o_led_alarm       = s_q.alarm;
	assign o_led_normal      = !s_q.alarm;
	assign o_relay_nc_closed = !s_q.alarm;
	assign o_relay_no_closed = s_q.alarm;

endmodule // fan_speed_pwm_control

// >>> include/fan_consts.svh
// Register offsets, field positions, reset values and timing counts of the fan controller.
`ifndef FAN_CONSTS_SVH
`define FAN_CONSTS_SVH

`define FAN_CLK_HZ            25000000
`define FAN_NUM_FANS          9
`define FAN_PWM_FREQ_HZ       2500
`define FAN_PWM_STEPS         100
`define FAN_PWM_PRESCALE      (`FAN_CLK_HZ / (`FAN_PWM_FREQ_HZ * `FAN_PWM_STEPS))
`define FAN_TACH_WINDOW_MS    600
`define FAN_TACH_WINDOW_CYC   ((`FAN_CLK_HZ / 1000) * `FAN_TACH_WINDOW_MS)
`define FAN_TACH_FAIL_PPM     2000
`define FAN_TACH_MIN_PULSES   ((`FAN_TACH_FAIL_PPM * `FAN_TACH_WINDOW_MS) / 60000)

`define FAN_REG_CONFIG        8'hf0
`define FAN_REG_SPEED_CMD     8'hf1
`define FAN_REG_OFF_TEMP      8'hf2
`define FAN_REG_ALARM_TEMP    8'hf3
`define FAN_REG_IDLE_DUTY     8'hf4
`define FAN_REG_FAN_EN_LO     8'hf5
`define FAN_REG_FAN_EN_HI     8'hf6
`define FAN_REG_FAIL_LO       8'hf7
`define FAN_REG_STATUS        8'hf8
`define FAN_REG_SETPOINT      8'hf9
`define FAN_REG_REMOTE_TEMP   8'hfa
`define FAN_REG_BOARD_TEMP    8'hfb

`define FAN_CFG_MODE_BIT      0
`define FAN_CFG_SENSOR_BIT    1
`define FAN_CFG_SLOPE_BIT     2
`define FAN_CFG_OFF_EN_BIT    3

`define FAN_RST_SETPOINT      8'h28
`define FAN_RST_IDLE_DUTY     7'h37
`define FAN_RST_OFF_TEMP      8'h00
`define FAN_RST_ALARM_TEMP    8'h3c
`define FAN_RST_FAN_EN        9'h1ff
`define FAN_DUTY_FULL         7'h64
`define FAN_SLOPE_NARROW      8'h05
`define FAN_SLOPE_WIDE        8'h0a

`endif

// >>> include/fan_pkg.sv
// Types shared by the fan speed controller, its host model and its checks.
package fan_pkg;

	typedef enum logic {
		MODE_TEMP,
		MODE_CMD
	} ctrl_mode_e;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_wr_s;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
	} reg_rd_s;

endpackage

// >>> src/fan_tach_monitor.sv
// Counts tach pulses of one fan over a window and flags a slow fan.
`timescale 1ns/1ns
`include "fan_consts.svh"

module fan_tach_monitor (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Tach and window
	input  wire logic i_tach,
	input  wire logic i_window_end,
	// Result
	output logic      o_fail
);

	typedef struct packed {
		logic       tach_prev;
		logic [7:0] count;
		logic       fail;
	} tach_state_s;

	localparam logic [7:0] MinPulses = 8'(`FAN_TACH_MIN_PULSES);

	tach_state_s s_q;
	tach_state_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.tach_prev = i_tach;
		if (i_tach && !s_q.tach_prev && s_q.count != 8'hff) begin
			s_d.count = s_q.count + 8'h01;
		end
		if (i_window_end) begin
			s_d.fail  = s_q.count < MinPulses;
			s_d.count = 8'h00;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_fail = s_q.fail;

endmodule // fan_tach_monitor

// >>> tb/fan_speed_pwm_control_assertions.sv
// Port level checks of the fan controller.
`timescale 1ns/1ns
`include "fan_consts.svh"
module fan_speed_pwm_control_assertions #(
	parameter int unsigned TACH_WINDOW_CYC = `FAN_TACH_WINDOW_CYC
) (
	// Clock and reset
	input wire logic                     i_clk,
	input wire logic                     i_rst,
	// Register ports
	input wire fan_pkg::reg_rd_s         i_pri_rd,
	input wire fan_pkg::reg_rd_s         i_sec_rd,
	input wire logic [7:0]               o_pri_rd_data,
	input wire logic [7:0]               o_sec_rd_data,
	// Sensors, fans and alarms
	input wire logic                     i_sensor_open,
	input wire logic [`FAN_NUM_FANS-1:0] o_fan_pwm,
	input wire logic                     o_led_alarm,
	input wire logic                     o_led_normal,
	input wire logic                     o_relay_nc_closed,
	input wire logic                     o_relay_no_closed
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	led_pair_a: assert property (o_led_normal == !o_led_alarm) else $error("led pair");
	relay_nc_a: assert property (o_relay_nc_closed == !o_led_alarm) else $error("nc relay");
	relay_no_a: assert property (o_relay_no_closed == o_led_alarm) else $error("no relay");
	open_alarm_a: assert property (i_sensor_open |-> ##[1:2] o_led_alarm)
		else $error("open sensor no alarm");
	// Fans only fall during an alarm if the host disables them, which the bench avoids.
	alarm_full_a: assert property (o_led_alarm [*4] |->
		(o_fan_pwm & $past(o_fan_pwm)) == $past(o_fan_pwm))
		else $error("pwm fell in alarm");
	pri_hold_a: assert property (!i_pri_rd.en |=> $stable(o_pri_rd_data)) else $error("pri data");
	sec_hold_a: assert property (!i_sec_rd.en |=> $stable(o_sec_rd_data)) else $error("sec data");
	reset_quiet_a: assert property (disable iff (1'b0) i_rst |=> (o_fan_pwm == '0) && o_led_normal)
		else $error("reset outputs");
endmodule // fan_speed_pwm_control_assertions

bind fan_speed_pwm_control fan_speed_pwm_control_assertions #(
	.TACH_WINDOW_CYC(TACH_WINDOW_CYC)
) chk_inst (.i_clk(i_clk), .i_rst(i_rst), .i_pri_rd(i_pri_rd), .i_sec_rd(i_sec_rd),
	.o_pri_rd_data(o_pri_rd_data), .o_sec_rd_data(o_sec_rd_data), .i_sensor_open(i_sensor_open),
	.o_fan_pwm(o_fan_pwm), .o_led_alarm(o_led_alarm), .o_led_normal(o_led_normal),
	.o_relay_nc_closed(o_relay_nc_closed), .o_relay_no_closed(o_relay_no_closed));

// >>> tb/fan_host.sv
// Register host model issuing byte reads and writes on one port.
`timescale 1ns/1ns
module fan_host (
	// Clock and read data
	input  wire logic        i_clk,
	input  wire logic [7:0]  i_rd_data,
	// Requests
	output fan_pkg::reg_wr_s o_wr,
	output fan_pkg::reg_rd_s o_rd
);
	initial begin
		o_wr = '0;
		o_rd = '0;
	end
	// A strobe lasts one edge only, so a held request never acts twice.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr <= {1'b1, a, d};
		@(posedge i_clk);
		o_wr <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_rd <= {1'b1, a};
		@(posedge i_clk);
		o_rd <= '0;
		// The read data is registered, so it is taken one edge after the request is seen.
		@(posedge i_clk);
		d = i_rd_data;
	endtask
endmodule // fan_host

// >>> tb/fan_speed_pwm_control_tb_top.sv
// Self-checking bench of the fan controller.
`timescale 1ns/1ns
module fan_speed_pwm_control_tb_top;
	logic clk, rst, open, alm, nrm;
	fan_pkg::reg_wr_s pw, sw;
	fan_pkg::reg_rd_s pr, sr;
	logic [7:0] pq, sq, remote, board, d;
	logic [8:0] tach, tach_on, pwm;
	logic [2:0] cnt;
	int err_total, check_count;
	fan_speed_pwm_control #(.TACH_WINDOW_CYC(1000)) fan_speed_pwm_control_inst (.i_clk(clk),
		.i_rst(rst), .i_pri_wr(pw), .i_pri_rd(pr), .o_pri_rd_data(pq), .i_sec_wr(sw),
		.i_sec_rd(sr), .o_sec_rd_data(sq), .i_remote_temp(remote), .i_board_temp(board),
		.i_sensor_open(open), .i_tach(tach), .o_fan_pwm(pwm), .o_led_alarm(alm),
		.o_led_normal(nrm), .o_relay_nc_closed(), .o_relay_no_closed());
	fan_host fan_host_inst (.i_clk(clk), .i_rd_data(pq), .o_wr(pw), .o_rd(pr));
	fan_host fan_host_sec_inst (.i_clk(clk), .i_rd_data(sq), .o_wr(sw), .o_rd(sr));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Each tach line set in tach_on gives one rising edge every eight clocks, far above the fail limit.
	always @(posedge clk) begin
		cnt <= rst ? 3'h0 : cnt + 3'h1;
		tach <= rst ? 9'h000 : tach_on & {9{cnt[2]}};
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// A change may land just at a period end, so a little more than one period is skipped.
	task automatic duty(input logic [15:0] exp, input int unsigned len);
		logic [15:0] hi;
		hi = 16'h0000;
		repeat (10010) @(posedge clk);
		repeat (len) begin
			@(posedge clk);
			hi = hi + 16'(pwm[0]);
		end
		check(hi, exp);
	endtask
	task automatic t_regs;
		fan_host_inst.rd(8'hf9, d);
		check(d, 16'h28);
		fan_host_inst.rd(8'hf0, d);
		check(d, 16'h00);
		fan_host_inst.rd(8'h20, d);
		check(d, 16'h00);
		fan_host_inst.rd(8'hfa, d);
		check(d, 16'h14);
		fan_host_sec_inst.rd(8'hfb, d);
		check(d, 16'h1e);
		fan_host_inst.wr(8'hf9, 8'h30);
		fan_host_sec_inst.rd(8'hf9, d);
		check(d, 16'h30);
		fan_host_sec_inst.wr(8'hf3, 8'h50);
		fan_host_inst.rd(8'hf3, d);
		check(d, 16'h50);
		fork
			fan_host_inst.wr(8'hf9, 8'h28);
			fan_host_sec_inst.wr(8'hf9, 8'h14);
		join
		fan_host_inst.rd(8'hf9, d);
		check(d, 16'h28);
		$display("registers done");
	endtask
	task automatic t_ramp;
		remote <= 8'h14;
		duty(16'h157c, 10000);
		remote <= 8'h25;
		duty(16'h1c84, 10000);
		fan_host_inst.wr(8'hf0, 8'h04);
		duty(16'h2198, 10000);
		board <= 8'h14;
		fan_host_inst.wr(8'hf2, 8'h19);
		fan_host_inst.wr(8'hf0, 8'h0a);
		duty(16'h0000, 2000);
		fan_host_inst.wr(8'hf0, 8'h00);
		$display("ramp done");
	endtask
	// The alarm temperature was moved to 80 degrees by the secondary port.
	task automatic t_alarm;
		remote <= 8'h5a;
		repeat (3) @(posedge clk);
		check(alm, 16'h1);
		fan_host_inst.rd(8'hf8, d);
		check(d, 16'h0c);
		remote <= 8'h14;
		open <= 1'b1;
		repeat (3) @(posedge clk);
		fan_host_inst.rd(8'hf8, d);
		check(d, 16'h06);
		open <= 1'b0;
		$display("alarm done");
	endtask
	task automatic t_fans;
		fan_host_inst.wr(8'hf5, 8'hf7);
		tach_on <= 9'h1f7;
		repeat (2200) @(posedge clk);
		check(alm, 16'h0);
		check(pwm[3], 16'h0);
		fan_host_inst.rd(8'hf7, d);
		check(d, 16'h00);
		fan_host_inst.wr(8'hf5, 8'hff);
		repeat (3) @(posedge clk);
		fan_host_inst.rd(8'hf7, d);
		check(d, 16'h08);
		check(alm, 16'h1);
		tach_on <= 9'h1ff;
		repeat (2200) @(posedge clk);
		check(alm, 16'h0);
		$display("fans done");
	endtask
	task automatic t_cmd;
		fan_host_inst.wr(8'hf1, 8'h32);
		fan_host_inst.rd(8'hf0, d);
		check(d, 16'h01);
		duty(16'h1388, 10000);
		$display("command done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// The scenarios need about 96500 clocks, nearly all of them in the duty measurements.
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		test_done();
	end
	initial begin
		{rst, open, tach_on, remote, board} = {1'b1, 1'b0, 9'h1ff, 16'h141e};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_alarm();
		t_fans();
		t_ramp();
		t_cmd();
		test_done();
	end
endmodule // fan_speed_pwm_control_tb_top
